// ### logic/ldo_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ldo_defines.svh"

// Operation
// - drive types A/B/spare, reset all ones
// - floppy index f3 reads zero, read-only
// - drive0 type select and rate table
// - option bits 2,5,7 read zero
// - bit6 set disables write precompensation
// - drive1 option mirrors drive0 layout
// - parallel mode field selects protocol
// - ECP FIFO threshold, reset 0111
// - interrupt type one pulses low, releases
// - type zero: IRQ follows nACK
// - ECP, test, FIFO modes: level IRQ
// - type ignored in printer, SPP modes
// - mode2 timeout clear style bit 4
// - serial1 bit0 enables MIDI
// - serial1 bit1 enables high speed
// - serial1 bit7 shares one UART IRQ
// - parallel mode resets to 3c
// - sharing asserts every configured UART line
module ldo_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic main_por_i,
  input wire logic standby_power_on_reset_i,
  input wire logic [7:0] ldn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic [7:0] drive_types_o,
  output logic [1:0] drive0_type_sel_o,
  output logic [1:0] drive0_rate_table_sel_o,
  output logic [1:0] drive1_type_sel_o,
  output logic [1:0] drive1_rate_table_sel_o,
  output logic [1:0] precomp_apply_o,
  output logic [2:0] pp_mode_o,
  output logic [3:0] ecp_threshold_o,
  output logic epp_timeout_w1c_o,
  output logic midi_en_o,
  output logic high_speed_o,
  output logic share_irq_o,
  input wire logic pp_ack_n_i,
  input wire logic pp_core_irq_i,
  input wire logic [2:0] ecr_mode_i,
  output logic pp_irq_o,
  output logic pp_irq_oe_o,
  input wire logic uart1_irq_i,
  input wire logic uart2_irq_i,
  input wire logic uart1_has_line_i,
  input wire logic uart2_has_line_i,
  output logic uart1_line_o,
  output logic uart2_line_o
);

  // ----------------------------------------
  // Reset and decode
  // ----------------------------------------
  // All three reset sources load the same defaults
  logic any_rst;
  assign any_rst = rst_i | main_por_i | standby_power_on_reset_i;

  function automatic logic reg_hit(input logic [7:0] ldn, input logic [7:0] idx,
                                   input logic [7:0] want_ldn, input logic [7:0] want_idx);
    reg_hit = (ldn == want_ldn) && (idx == want_idx);
  endfunction : reg_hit

  // Same index in distinct devices is distinct storage
  logic hit_pmode, hit_smode, hit_pmode2, hit_dtypes, hit_spare, hit_d0, hit_d1;
  assign hit_pmode = reg_hit(ldn_i, addr_i, `LDO_LDN_PARALLEL, `LDO_IDX_PARALLEL_MODE);
  assign hit_smode = reg_hit(ldn_i, addr_i, `LDO_LDN_SERIAL1, `LDO_IDX_SERIAL1_MODE);
  assign hit_pmode2 = reg_hit(ldn_i, addr_i, `LDO_LDN_PARALLEL, `LDO_IDX_PARALLEL_MODE_2);
  assign hit_dtypes = reg_hit(ldn_i, addr_i, `LDO_LDN_FLOPPY, `LDO_IDX_DRIVE_TYPES);
  assign hit_spare = reg_hit(ldn_i, addr_i, `LDO_LDN_FLOPPY, `LDO_IDX_FLOPPY_SPARE);
  assign hit_d0 = reg_hit(ldn_i, addr_i, `LDO_LDN_FLOPPY, `LDO_IDX_DRIVE0_OPTION);
  assign hit_d1 = reg_hit(ldn_i, addr_i, `LDO_LDN_FLOPPY, `LDO_IDX_DRIVE1_OPTION);
  // Spare index and foreign devices fall through to zero
  logic hit_none;
  assign hit_none = ~|{hit_pmode, hit_smode, hit_pmode2, hit_dtypes, hit_d0, hit_d1};

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] pmode_r, smode_r, pmode2_r, dtypes_r;
  logic [7:0] dopt_r [2];
  logic [1:0] dopt_hit;
  assign dopt_hit = {hit_d1, hit_d0};

  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      pmode_r <= `LDO_RST_PARALLEL_MODE;
      smode_r <= `LDO_RST_SERIAL1_MODE;
      pmode2_r <= `LDO_RST_PARALLEL_MODE_2;
      dtypes_r <= `LDO_RST_DRIVE_TYPES;
    end
    else if (wr_i)
    begin
      if (hit_pmode)
        pmode_r <= wdata_i;
      if (hit_smode)
        smode_r <= wdata_i;
      if (hit_pmode2)
        pmode2_r <= wdata_i;
      if (hit_dtypes)
        dtypes_r <= wdata_i;
    end
  end

  // Both drive option registers share one layout
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_dopt
      always_ff @(posedge clk_i)
      begin
        if (any_rst)
          dopt_r[g] <= `LDO_RST_DRIVE_OPTION;
        else if (wr_i && dopt_hit[g])
          dopt_r[g] <= wdata_i & `LDO_DRIVE_OPTION_MASK;
      end
      assign precomp_apply_o[g] = ~dopt_r[g][`LDO_PRECOMP_BIT];
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped and spare indices answer zero
  logic [7:0] rd_mux;
  assign rd_mux = hit_pmode ? pmode_r :
                  hit_smode ? smode_r :
                  hit_pmode2 ? pmode2_r :
                  hit_dtypes ? dtypes_r :
                  hit_d0 ? dopt_r[0] :
                  hit_d1 ? dopt_r[1] :
                  8'h00;

  always_ff @(posedge clk_i)
  begin
    if (any_rst)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rd_mux;
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  assign drive_types_o = dtypes_r;
  assign drive0_type_sel_o = dopt_r[0][1:0];
  assign drive0_rate_table_sel_o = dopt_r[0][4:3];
  assign drive1_type_sel_o = dopt_r[1][1:0];
  assign drive1_rate_table_sel_o = dopt_r[1][4:3];
  assign pp_mode_o = pmode_r[2:0];
  assign ecp_threshold_o = pmode_r[6:3];
  // Zero selects clear-on-write-one of the timeout flag
  assign epp_timeout_w1c_o = ~pmode2_r[`LDO_TIMEOUT_SEL_BIT];
  assign midi_en_o = smode_r[`LDO_MIDI_BIT];
  assign high_speed_o = smode_r[`LDO_HIGH_SPEED_BIT];
  assign share_irq_o = smode_r[`LDO_SHARE_IRQ_BIT];

  // ----------------------------------------
  // UART interrupt sharing
  // ----------------------------------------
  // Unconfigured line stays quiet even when shared
  logic uart_any;
  assign uart_any = uart1_irq_i | uart2_irq_i;
  assign uart1_line_o = share_irq_o ? (uart_any & uart1_has_line_i) : uart1_irq_i;
  assign uart2_line_o = share_irq_o ? (uart_any & uart2_has_line_i) : uart2_irq_i;

  // ----------------------------------------
  // Parallel port interrupt
  // ----------------------------------------
  // nACK is a pin: three stages, change taken when last two agree
  logic [2:0] ack_sync_r;
  logic ack_n_r;
  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      ack_sync_r <= 3'b111;
      ack_n_r <= 1'b1;
    end
    else
    begin
      ack_sync_r <= {ack_sync_r[1:0], pp_ack_n_i};
      if (ack_sync_r[2] == ack_sync_r[1])
        ack_n_r <= ack_sync_r[2];
    end
  end

  ldo_pkg::ldo_pp_mode_type pp_mode;
  ldo_pkg::ldo_ecr_mode_type ecr_mode;
  assign pp_mode = ldo_pkg::ldo_pp_mode_type'(pmode_r[2:0]);
  assign ecr_mode = ldo_pkg::ldo_ecr_mode_type'(ecr_mode_i);

  logic mode_basic, mode_epp, mode_ecp, ecr_follows_ack, follow_ack, pulse_type;
  assign mode_basic = (pp_mode == ldo_pkg::LDO_PP_PRINTER) || (pp_mode == ldo_pkg::LDO_PP_SPP);
  assign mode_epp = (pp_mode == ldo_pkg::LDO_PP_EPP19) || (pp_mode == ldo_pkg::LDO_PP_EPP17);
  assign mode_ecp = (pp_mode == ldo_pkg::LDO_PP_ECP) || (pp_mode == ldo_pkg::LDO_PP_ECP_EPP19) ||
                    (pp_mode == ldo_pkg::LDO_PP_ECP_EPP17);
  assign ecr_follows_ack = (ecr_mode == ldo_pkg::LDO_ECR_SPP) || (ecr_mode == ldo_pkg::LDO_ECR_PS2) ||
                           (ecr_mode == ldo_pkg::LDO_ECR_EPP);
  // Type bit is ignored in printer and standard modes
  assign pulse_type = pmode_r[`LDO_PP_IRQ_TYPE_BIT] & ~mode_basic;
  assign follow_ack = mode_basic | mode_epp | (mode_ecp & ecr_follows_ack);

  // Source level: nACK-tracking or core level request
  logic irq_src, irq_src_d_r, pulse_r;
  assign irq_src = follow_ack ? ack_n_r : pp_core_irq_i;

  always_ff @(posedge clk_i)
  begin
    if (any_rst)
    begin
      irq_src_d_r <= 1'b1;
      pulse_r <= 1'b0;
    end
    else
    begin
      irq_src_d_r <= irq_src;
      // One-cycle low pulse per rising source edge
      pulse_r <= pulse_type & irq_src & ~irq_src_d_r;
    end
  end

  // Pulsed style releases the pin outside the pulse
  assign pp_irq_o = pulse_type ? 1'b0 : irq_src;
  assign pp_irq_oe_o = pulse_type ? pulse_r : 1'b1;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (any_rst);

  sequence s_write(logic hit);
    wr_i && hit;
  endsequence

  sequence s_read(logic hit);
    rd_i && hit;
  endsequence

  a_drive_opt_mask: assert property (
    s_write(hit_d0) ##1 (rd_i && hit_d0) |=> (rdata_o[7] == 1'b0 && rdata_o[5] == 1'b0 && rdata_o[2] == 1'b0))
    else $error("drive option reserved bits read nonzero");

  a_spare_zero: assert property (
    (rd_i && hit_spare) |=> (rdata_o == 8'h00))
    else $error("floppy spare index read nonzero");

  a_dtypes_store: assert property (
    s_write(hit_dtypes) |=> (drive_types_o == $past(wdata_i)))
    else $error("drive type register lost write");

  a_precomp_ctrl: assert property (
    s_write(hit_d1) |=> (precomp_apply_o[1] == ~$past(wdata_i[6])))
    else $error("precompensation control wrong");

  a_drive1_fields: assert property (
    s_write(hit_d1) |=> (drive1_rate_table_sel_o == $past(wdata_i[4:3]) &&
                         drive1_type_sel_o == $past(wdata_i[1:0])))
    else $error("drive1 option fields wrong");

  a_ldn_isolated: assert property (
    s_write(hit_smode) |=> $stable(pp_mode_o) && $stable(ecp_threshold_o))
    else $error("serial write disturbed parallel register");

  a_share_both: assert property (
    (share_irq_o && uart1_has_line_i && uart2_has_line_i && uart2_irq_i) |-> (uart1_line_o && uart2_line_o))
    else $error("shared irq not on both lines");

  a_unshared_own: assert property (
    !share_irq_o |-> (uart1_line_o == uart1_irq_i && uart2_line_o == uart2_irq_i))
    else $error("unshared irq not routed to own line");

  a_basic_drive: assert property (
    mode_basic |-> (pp_irq_oe_o && pp_irq_o == ack_n_r))
    else $error("type bit acted in basic mode");

  a_pulse_low: assert property (
    (pulse_type && irq_src && !irq_src_d_r) ##1 pulse_type |-> (pp_irq_oe_o && !pp_irq_o) ##1 !pp_irq_oe_o)
    else $error("interrupt pulse wrong shape");

  a_ecp_level: assert property (
    (!pulse_type && mode_ecp && !ecr_follows_ack) |-> (pp_irq_o == pp_core_irq_i && pp_irq_oe_o))
    else $error("ECP level interrupt not passed");

  a_smode_readback: assert property (
    s_write(hit_smode) ##1 (rd_i && hit_smode) |=> (rdata_o == $past(wdata_i, 2)))
    else $error("serial mode readback wrong");

  a_pmode_store: assert property (
    s_write(hit_pmode) |=> (pp_mode_o == $past(wdata_i[2:0]) && ecp_threshold_o == $past(wdata_i[6:3])))
    else $error("parallel mode fields lost write");

  a_pmode2_store: assert property (
    s_write(hit_pmode2) |=> (epp_timeout_w1c_o == !$past(wdata_i[4])))
    else $error("timeout clear style wrong");

  a_smode_fields: assert property (
    s_write(hit_smode) |=> (midi_en_o == $past(wdata_i[0]) && high_speed_o == $past(wdata_i[1]) &&
                            share_irq_o == $past(wdata_i[7])))
    else $error("serial mode fields wrong");

  a_drive0_fields: assert property (
    s_write(hit_d0) |=> (drive0_rate_table_sel_o == $past(wdata_i[4:3]) &&
                         drive0_type_sel_o == $past(wdata_i[1:0]) && precomp_apply_o[0] == !$past(wdata_i[6])))
    else $error("drive0 option fields wrong");

  a_pmode2_readback: assert property (
    s_write(hit_pmode2) ##1 s_read(hit_pmode2) |=> (rdata_o == $past(wdata_i, 2)))
    else $error("mode2 readback wrong");

  a_dtypes_readback: assert property (
    s_write(hit_dtypes) ##1 s_read(hit_dtypes) |=> (rdata_o == $past(wdata_i, 2)))
    else $error("drive type readback wrong");

  a_drive1_readback: assert property (
    s_write(hit_d1) ##1 s_read(hit_d1) |=> (rdata_o == ($past(wdata_i, 2) & `LDO_DRIVE_OPTION_MASK)))
    else $error("drive1 option readback wrong");

  a_unmapped_zero: assert property (
    s_read(hit_none) |=> (rdata_o == 8'h00))
    else $error("unmapped index read nonzero");

  a_ldn_serial_apart: assert property (
    s_write(hit_pmode) |=> ($stable(share_irq_o) && $stable(midi_en_o) && $stable(high_speed_o)))
    else $error("parallel write disturbed serial register");

  a_ack_follow: assert property (
    (follow_ack && !pulse_type) |-> (pp_irq_oe_o && pp_irq_o == ack_n_r))
    else $error("interrupt not following acknowledge");

  a_pulse_released: assert property (
    pulse_type |-> (!pp_irq_o && pp_irq_oe_o == pulse_r))
    else $error("pulsed interrupt driven outside pulse");

  a_pulse_single: assert property (
    (pulse_type && pp_irq_oe_o) ##1 pulse_type |-> !pp_irq_oe_o)
    else $error("interrupt pulse longer than one cycle");

  a_uart1_shared: assert property (
    (share_irq_o && (uart1_irq_i || uart2_irq_i) && uart1_has_line_i) |-> uart1_line_o)
    else $error("shared irq missing on first line");

  a_unconfigured_quiet: assert property (
    (share_irq_o && !uart2_has_line_i) |-> !uart2_line_o)
    else $error("unconfigured line driven while shared");

  // Reset checks override the default disable, which would mask them
  a_reset_parallel: assert property (
    disable iff (1'b0) any_rst |=> ({1'b0, ecp_threshold_o, pp_mode_o} == `LDO_RST_PARALLEL_MODE))
    else $error("parallel mode reset value wrong");

  a_reset_floppy: assert property (
    disable iff (1'b0) any_rst |=> (drive_types_o == `LDO_RST_DRIVE_TYPES && precomp_apply_o == 2'b11 &&
                                    {drive1_rate_table_sel_o, drive1_type_sel_o, drive0_rate_table_sel_o,
                                     drive0_type_sel_o} == 8'h00))
    else $error("floppy reset values wrong");

  a_reset_serial: assert property (
    disable iff (1'b0) any_rst |=> ({share_irq_o, high_speed_o, midi_en_o} == 3'b000 && epp_timeout_w1c_o &&
                                    rdata_o == 8'h00))
    else $error("serial or mode2 reset values wrong");

endmodule : ldo_regs
`default_nettype wire

// ### pkg/ldo_defines.svh
`ifndef LDO_DEFINES_SVH
`define LDO_DEFINES_SVH

// ----------------------------------------
// Logical device numbers
// ----------------------------------------
`define LDO_LDN_FLOPPY 8'h00
`define LDO_LDN_PARALLEL 8'h03
`define LDO_LDN_SERIAL1 8'h04

// ----------------------------------------
// Register indices
// ----------------------------------------
`define LDO_IDX_PARALLEL_MODE 8'hf0
`define LDO_IDX_SERIAL1_MODE 8'hf0
`define LDO_IDX_PARALLEL_MODE_2 8'hf1
`define LDO_IDX_DRIVE_TYPES 8'hf2
`define LDO_IDX_FLOPPY_SPARE 8'hf3
`define LDO_IDX_DRIVE0_OPTION 8'hf4
`define LDO_IDX_DRIVE1_OPTION 8'hf5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LDO_RST_PARALLEL_MODE 8'h3c
`define LDO_RST_SERIAL1_MODE 8'h00
`define LDO_RST_PARALLEL_MODE_2 8'h00
`define LDO_RST_DRIVE_TYPES 8'hff
`define LDO_RST_DRIVE_OPTION 8'h00

// ----------------------------------------
// Field positions and writable masks
// ----------------------------------------
`define LDO_DRIVE_OPTION_MASK 8'h5b
`define LDO_PRECOMP_BIT 6
`define LDO_PP_IRQ_TYPE_BIT 7
`define LDO_TIMEOUT_SEL_BIT 4
`define LDO_MIDI_BIT 0
`define LDO_HIGH_SPEED_BIT 1
`define LDO_SHARE_IRQ_BIT 7

`endif

// ### pkg/ldo_pkg.sv
package ldo_pkg;

  // Parallel port protocol mode field
  typedef enum logic [2:0] {
    LDO_PP_SPP = 3'b000,
    LDO_PP_EPP19 = 3'b001,
    LDO_PP_ECP = 3'b010,
    LDO_PP_ECP_EPP19 = 3'b011,
    LDO_PP_PRINTER = 3'b100,
    LDO_PP_EPP17 = 3'b101,
    LDO_PP_RSVD = 3'b110,
    LDO_PP_ECP_EPP17 = 3'b111
  } ldo_pp_mode_type;

  // Sub-mode reported by the ECP core while in an ECP mode
  typedef enum logic [2:0] {
    LDO_ECR_SPP = 3'b000,
    LDO_ECR_PS2 = 3'b001,
    LDO_ECR_FIFO = 3'b010,
    LDO_ECR_ECP = 3'b011,
    LDO_ECR_EPP = 3'b100,
    LDO_ECR_RSVD = 3'b101,
    LDO_ECR_TEST = 3'b110,
    LDO_ECR_CFG = 3'b111
  } ldo_ecr_mode_type;

endpackage : ldo_pkg

// ### dv/ldo_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ldo_defines.svh"

module ldo_regs_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic main_por_i = 1'b0;
  logic standby_power_on_reset_i = 1'b0;
  logic [7:0] ldn_i = 8'h00;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pp_ack_n_i = 1'b1;
  logic pp_core_irq_i = 1'b0;
  logic [2:0] ecr_mode_i = 3'h0;
  logic uart1_irq_i = 1'b0;
  logic uart2_irq_i = 1'b0;
  logic uart1_has_line_i = 1'b0;
  logic uart2_has_line_i = 1'b0;
  logic [7:0] rdata_o, drive_types_o;
  logic [1:0] d0_type, d0_rate, d1_type, d1_rate, precomp_apply_o;
  logic [2:0] pp_mode_o;
  logic [3:0] ecp_threshold_o;
  logic epp_timeout_w1c_o, midi_en_o, high_speed_o, share_irq_o;
  logic pp_irq_o, pp_irq_oe_o, uart1_line_o, uart2_line_o;
  int n_errors = 0;
  int num_checks = 0;

  ldo_regs dut (.clk_i(clk_i), .rst_i(rst_i), .main_por_i(main_por_i),
    .standby_power_on_reset_i(standby_power_on_reset_i), .ldn_i(ldn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .drive_types_o(drive_types_o), .drive0_type_sel_o(d0_type),
    .drive0_rate_table_sel_o(d0_rate), .drive1_type_sel_o(d1_type), .drive1_rate_table_sel_o(d1_rate),
    .precomp_apply_o(precomp_apply_o), .pp_mode_o(pp_mode_o), .ecp_threshold_o(ecp_threshold_o),
    .epp_timeout_w1c_o(epp_timeout_w1c_o), .midi_en_o(midi_en_o), .high_speed_o(high_speed_o),
    .share_irq_o(share_irq_o), .pp_ack_n_i(pp_ack_n_i), .pp_core_irq_i(pp_core_irq_i), .ecr_mode_i(ecr_mode_i),
    .pp_irq_o(pp_irq_o), .pp_irq_oe_o(pp_irq_oe_o), .uart1_irq_i(uart1_irq_i), .uart2_irq_i(uart2_irq_i),
    .uart1_has_line_i(uart1_has_line_i), .uart2_has_line_i(uart2_has_line_i), .uart1_line_o(uart1_line_o),
    .uart2_line_o(uart2_line_o));

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] l, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ldn_i <= l;
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] l, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    ldn_i <= l;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd_chk

  // Write, then read back in the very next cycle
  task automatic wr_rd_chk(input logic [7:0] l, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk_i);
    ldn_i <= l;
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : wr_rd_chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cycles

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    rd_chk(`LDO_LDN_FLOPPY, 8'hf2, 8'hff);
    rd_chk(`LDO_LDN_FLOPPY, 8'hf4, 8'h00);
    rd_chk(`LDO_LDN_FLOPPY, 8'hf5, 8'h00);
    rd_chk(`LDO_LDN_PARALLEL, 8'hf0, 8'h3c);
    rd_chk(`LDO_LDN_SERIAL1, 8'hf0, 8'h00);
    chk({1'b0, pp_mode_o, ecp_threshold_o}, 8'h47);
    chk({5'h0, share_irq_o, high_speed_o, midi_en_o}, 8'h00);
  endtask : t_reset_values

  task automatic t_floppy;
    wr_rd_chk(`LDO_LDN_FLOPPY, 8'hf2, 8'ha5, 8'ha5);
    chk(drive_types_o, 8'ha5);
    wr_rd_chk(`LDO_LDN_FLOPPY, 8'hf4, 8'hff, 8'h5b);
    chk({4'h0, d0_rate, d0_type}, 8'h0f);
    chk({6'h0, precomp_apply_o}, 8'h02);
    wr_rd_chk(`LDO_LDN_FLOPPY, 8'hf5, 8'hd2, 8'h52);
    chk({4'h0, d1_rate, d1_type}, 8'h0a);
    reg_wr(`LDO_LDN_FLOPPY, 8'hf4, 8'h09);
    cycles(1);
    chk({2'h0, precomp_apply_o, d0_rate, d0_type}, 8'h15);
    reg_wr(`LDO_LDN_FLOPPY, 8'hf3, 8'hff);
    rd_chk(`LDO_LDN_FLOPPY, 8'hf3, 8'h00);
    rd_chk(`LDO_LDN_PARALLEL, 8'hf4, 8'h00);
  endtask : t_floppy

  task automatic t_devices;
    wr_rd_chk(`LDO_LDN_SERIAL1, 8'hf0, 8'h83, 8'h83);
    rd_chk(`LDO_LDN_PARALLEL, 8'hf0, 8'h3c);
    chk({5'h0, share_irq_o, high_speed_o, midi_en_o}, 8'h07);
    rd_chk(8'h07, 8'hf0, 8'h00);
    wr_rd_chk(`LDO_LDN_PARALLEL, 8'hf1, 8'h10, 8'h10);
    chk({7'h0, epp_timeout_w1c_o}, 8'h00);
    reg_wr(`LDO_LDN_PARALLEL, 8'hf1, 8'h00);
    cycles(1);
    chk({7'h0, epp_timeout_w1c_o}, 8'h01);
  endtask : t_devices

  task automatic t_uart_share;
    logic any;
    for (int s = 0; s < 2; s++)
    begin
      reg_wr(`LDO_LDN_SERIAL1, 8'hf0, {s[0], 7'h00});
      for (int i = 0; i < 16; i++)
      begin
        @(posedge clk_i);
        {uart1_irq_i, uart2_irq_i, uart1_has_line_i, uart2_has_line_i} <= i[3:0];
        cycles(1);
        any = i[3] | i[2];
        chk({6'h0, uart1_line_o, uart2_line_o}, {6'h0, s[0] ? {any & i[1], any & i[0]} : i[3:2]});
      end
    end
  endtask : t_uart_share

  // Each case: mode byte, core sub-mode, and whether the core request is the source
  task automatic t_pp_levels;
    logic [7:0] modes [9] = '{8'hbc, 8'hb8, 8'h39, 8'h3d, 8'h3a, 8'h3a, 8'h3b, 8'h3f, 8'h3b};
    logic [2:0] ecrs [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h4, 3'h6, 3'h3};
    logic [8:0] core = 9'b110100000;
    for (int c = 0; c < 9; c++)
    begin
      reg_wr(`LDO_LDN_PARALLEL, 8'hf0, modes[c]);
      ecr_mode_i <= ecrs[c];
      for (int lvl = 0; lvl < 2; lvl++)
      begin
        @(posedge clk_i);
        pp_ack_n_i <= core[c] ? ~lvl[0] : lvl[0];
        pp_core_irq_i <= core[c] ? lvl[0] : ~lvl[0];
        cycles(6);
        chk({pp_irq_oe_o, pp_irq_o, 3'h0, pp_mode_o}, {1'b1, lvl[0], 3'h0, modes[c][2:0]});
      end
    end
  endtask : t_pp_levels

  // Pulse mode: exactly one driven-low cycle per rising source, released otherwise
  task automatic t_pp_pulse;
    int seen;
    for (int src = 0; src < 2; src++)
    begin
      reg_wr(`LDO_LDN_PARALLEL, 8'hf0, 8'hba);
      ecr_mode_i <= src ? 3'h2 : 3'h0;
      pp_core_irq_i <= 1'b0;
      pp_ack_n_i <= src[0];
      cycles(6);
      chk({7'h0, pp_irq_oe_o}, 8'h00);
      @(posedge clk_i);
      if (src == 1)
        pp_core_irq_i <= 1'b1;
      else
        pp_ack_n_i <= 1'b1;
      seen = 0;
      for (int k = 0; k < 8; k++)
      begin
        cycles(1);
        if (pp_irq_oe_o === 1'b1)
        begin
          seen++;
          chk({7'h0, pp_irq_o}, 8'h00);
        end
      end
      chk(seen[7:0], 8'h01);
    end
  endtask : t_pp_pulse

  task automatic t_resets;
    for (int k = 0; k < 3; k++)
    begin
      reg_wr(`LDO_LDN_PARALLEL, 8'hf0, 8'h12);
      cycles(1);
      chk({1'b0, pp_mode_o, ecp_threshold_o}, 8'h22);
      reg_wr(`LDO_LDN_FLOPPY, 8'hf2, 8'h00);
      @(posedge clk_i);
      {rst_i, main_por_i, standby_power_on_reset_i} <= 3'b100 >> k;
      @(posedge clk_i);
      @(posedge clk_i);
      {rst_i, main_por_i, standby_power_on_reset_i} <= 3'b000;
      rd_chk(`LDO_LDN_PARALLEL, 8'hf0, 8'h3c);
      rd_chk(`LDO_LDN_FLOPPY, 8'hf2, 8'hff);
    end
  endtask : t_resets

  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_floppy();
    t_devices();
    t_uart_share();
    t_pp_levels();
    t_pp_pulse();
    t_resets();
    final_report();
  end
endmodule : ldo_regs_tb_top

`default_nettype wire
